/* pkg/charger_pkg.sv */
// Purpose: Shared constants and types for the charger mode and fault link
// Assumes: One 40 MHz system clock for both ends
// Notes:   Link registers are 16 bits wide, three address bits
package charger_pkg;

    // Link geometry
    localparam int LINK_AW = 3;
    localparam int LINK_DW = 16;

    // Device register offsets
    localparam logic [2:0] REG_CONTROL = 3'h0;
    localparam logic [2:0] REG_FAULT   = 3'h1;
    localparam logic [2:0] REG_STATUS  = 3'h2;
    localparam logic [2:0] REG_PARAMS  = 3'h3;
    localparam logic [2:0] REG_SAFETY  = 3'h4;

    // Control field positions
    localparam int CTL_INHIBIT   = 0;
    localparam int CTL_HIZ_REQ   = 1;
    localparam int CTL_OPSEL     = 2;
    localparam int CTL_OTG_FUNCTION_ENABLE    = 3;
    localparam int CTL_STAT_EN   = 4;
    localparam int CTL_PARAM_RST = 5;
    localparam int CTL_TMR_RST   = 6;
    localparam int CTL_W         = 7;
    localparam logic [6:0] CTL_RESET = 7'h10;

    // Fault field positions
    localparam int F_TIMER    = 0;
    localparam int F_SLEEP    = 1;
    localparam int F_BUS_OV   = 2;
    localparam int F_BAT_OV   = 3;
    localparam int F_POOR_SRC = 4;
    localparam int F_UVLO     = 5;
    localparam int F_NO_BAT   = 6;
    localparam int F_THERMAL  = 7;
    localparam int F_OVERLOAD = 8;
    localparam int F_BAT_LOW  = 9;
    localparam int F_W        = 10;
    localparam logic [9:0] CHARGE_FAULT_MASK = 10'h0ff;
    localparam logic [9:0] BOOST_FAULT_MASK  = 10'h38d;

    // Reset values of data registers
    localparam logic [15:0] PARAM_DEFAULT  = 16'h0000;
    localparam logic [15:0] SAFETY_DEFAULT = 16'h0000;
    localparam logic [15:0] UNMAPPED_READ  = 16'hffff;

    // Timing
    localparam int CLK_MHZ         = 40;
    localparam int FAULT_PULSE_NS  = 128000;
    localparam int FAULT_PULSE_CYC = (FAULT_PULSE_NS * CLK_MHZ + 999) / 1000;
    localparam int OVERLOAD_MS     = 30;
    localparam int OVERLOAD_CYC    = OVERLOAD_MS * CLK_MHZ * 1000 + 1;

    // Host user port
    localparam int USER_AW = 3;
    localparam int USER_DW = 32;
    localparam logic [2:0] U_PINS    = 3'h0;
    localparam logic [2:0] U_LINK_WR = 3'h1;
    localparam logic [2:0] U_LINK_RD = 3'h2;
    localparam logic [2:0] U_RD_DATA = 3'h3;
    localparam logic [2:0] U_STAT    = 3'h4;
    localparam int U_PIN_CD  = 0;
    localparam int U_PIN_OTG = 1;

    typedef enum logic [3:0] {
        MODE_HIZ    = 4'h1,
        MODE_CHARGE = 4'h2,
        MODE_CONFIG = 4'h4,
        MODE_BOOST  = 4'h8
    } mode_type;

endpackage

/* pkg/charger_link_if.sv */
// Purpose: Pins and register link between host and charger logic
// Assumes: Status pin is open drain with an external pull-up
// Notes:   Pin level is resolved here from the device enable
`timescale 1ns/1ps
interface charger_link_if;
    import charger_pkg::*;
    logic                 cd;
    logic                 otg;
    logic                 wr;
    logic                 rd;
    logic [LINK_AW-1:0]   addr;
    logic [LINK_DW-1:0]   wdata;
    logic [LINK_DW-1:0]   rdata;
    logic                 stat_o;
    logic                 stat_oe;
    logic                 stat_level;

    // Pull-up unless the device pulls low
    assign stat_level = stat_oe ? stat_o : 1'b1;

    modport device (
        input  cd, otg, wr, rd, addr, wdata,
        output rdata, stat_o, stat_oe
    );
    modport host (
        output cd, otg, wr, rd, addr, wdata,
        input  rdata, stat_level
    );
endinterface

/* design/charger_host.sv */
// Purpose: Host end driving charger pins and register link
// Assumes: Plain register port, read data one cycle after strobe
// Notes:   Link reads are posted; result is fetched from a data register
`timescale 1ns/1ps
module charger_host
    import charger_pkg::*;
(
    // Clock and reset
    input  wire logic                clk_i,
    input  wire logic                arst_n_i,
    // User register port
    input  wire logic [USER_AW-1:0]  addr_i,
    input  wire logic [USER_DW-1:0]  wdata_i,
    input  wire logic                wr_i,
    input  wire logic                rd_i,
    output logic      [USER_DW-1:0]  rdata_o,
    // Charger link
    charger_link_if.host             link
);
    logic [1:0]          pins_reg;
    logic                lwr_reg;
    logic                lrd_reg;
    logic [2:0]          laddr_reg;
    logic [15:0]         lwdata_reg;
    logic                capture_reg;
    logic [15:0]         rd_data_reg;
    logic                rd_valid_reg;
    logic                stat_prev_reg;
    logic [7:0]          fall_cnt_reg;
    logic [USER_DW-1:0]  rdata_reg;
    logic [USER_DW-1:0]  rdata_next;

    wire wr_pins = wr_i && addr_i == U_PINS;
    wire wr_lwr  = wr_i && addr_i == U_LINK_WR;
    wire wr_lrd  = wr_i && addr_i == U_LINK_RD;
    wire wr_stat = wr_i && addr_i == U_STAT;
    wire stat_fall = stat_prev_reg && !link.stat_level;

    always_comb begin
        if (addr_i == U_PINS) begin
            rdata_next = {30'h0, pins_reg};
        end else if (addr_i == U_RD_DATA) begin
            rdata_next = {15'h0, rd_valid_reg, rd_data_reg};
        end else if (addr_i == U_STAT) begin
            rdata_next = {23'h0, fall_cnt_reg, link.stat_level};
        end else begin
            rdata_next = 32'h0;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pins_reg      <= 2'h0;
            lwr_reg       <= 1'b0;
            lrd_reg       <= 1'b0;
            laddr_reg     <= 3'h0;
            lwdata_reg    <= 16'h0;
            capture_reg   <= 1'b0;
            rd_data_reg   <= 16'h0;
            rd_valid_reg  <= 1'b0;
            stat_prev_reg <= 1'b1;
            fall_cnt_reg  <= 8'h0;
            rdata_reg     <= 32'h0;
        end else begin
            if (wr_pins) begin
                pins_reg <= wdata_i[1:0];
            end
            lwr_reg <= wr_lwr;
            lrd_reg <= wr_lrd;
            if (wr_lwr) begin
                laddr_reg  <= wdata_i[18:16];
                lwdata_reg <= wdata_i[15:0];
            end else if (wr_lrd) begin
                laddr_reg <= wdata_i[2:0];
            end
            capture_reg <= lrd_reg;
            if (capture_reg) begin
                rd_data_reg <= link.rdata;
            end
            if (capture_reg) begin
                rd_valid_reg <= 1'b1;
            end else if (wr_lrd) begin
                rd_valid_reg <= 1'b0;
            end
            stat_prev_reg <= link.stat_level;
            // Edge count: new edge wins over clear
            if (stat_fall) begin
                fall_cnt_reg <= wr_stat ? 8'h1 : fall_cnt_reg + 8'h1;
            end else if (wr_stat) begin
                fall_cnt_reg <= 8'h0;
            end
            if (rd_i) begin
                rdata_reg <= rdata_next;
            end else begin
                rdata_reg <= 32'h0;
            end
        end
    end

    // Parameter reset and restart writes are issued by software only
    assign link.cd    = pins_reg[U_PIN_CD];
    assign link.otg   = pins_reg[U_PIN_OTG];
    assign link.wr    = lwr_reg;
    assign link.rd    = lrd_reg;
    assign link.addr  = laddr_reg;
    assign link.wdata = lwdata_reg;
    assign rdata_o    = rdata_reg;
endmodule

/* design/charger_dev.sv */
// Purpose: Mode decode, fault handling and status pin of the charger
// Assumes: Analog comparators arrive as synchronous levels
// Notes:   Long counts are parameters so simulation can shorten them
// Notes on behaviour
// - Thermal shutdown stops charge, PWM, timers; hysteresis
// - Status low while charging with enable set
// - Fault gives one 128 us low pulse
// - Charge mode fault set listed
// - Boost mode fault set listed
// - Inhibit bit zero enables, one disables charge
// - Parameter reset restores defaults, bit self-clears
// - Host uses parameter reset only when idle
// - Select bit boosts; fault drops to configure
// - Charge, configure or high impedance decode
// - Disable pin high forces high impedance
// - Disable pin rise clears 15-minute timer only
// - Host mode: otg pin or select bit boosts; the pin boosts only with CTL_OTG_FUNCTION_ENABLE set
// - Light load pulse skipping with droop restart
// - Overvoltage stops boost, clears select bit
// - Restart needs select bit or otg pin
// - Overload declared after 30 ms unbroken
// - Overload blocks boost until faults cleared
// - Battery limits stop boost like other faults
// - Status open while boosting without fault
// - Fifteen-minute mode until first host write
// - Leave high impedance only when all permit
//
// The implementer's own choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
module charger_dev
    import charger_pkg::*;
#(
    parameter int PULSE_CYC = FAULT_PULSE_CYC,
    parameter int OVLD_CYC  = OVERLOAD_CYC
) (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        arst_n_i,
    // Host link
    charger_link_if.device   link,
    // Analog monitors
    input  wire logic        temp_shutdown_i,
    input  wire logic        temp_resumed_i,
    input  wire logic        bus_above_uvlo_i,
    input  wire logic        timer_fault_i,
    input  wire logic        sleep_i,
    input  wire logic        bus_ov_i,
    input  wire logic        bat_ov_i,
    input  wire logic        poor_src_i,
    input  wire logic        no_battery_i,
    input  wire logic        overload_i,
    input  wire logic        bat_low_i,
    input  wire logic        inductor_low_i,
    input  wire logic        node_droop_i,
    // Power stage controls
    output logic [3:0]       mode_o,
    output logic             pwm_on_o,
    output logic             charge_en_o,
    output logic             timers_frozen_o,
    output logic             safety_timer_clear_o,
    output logic             host_timer_mode_o,
    output logic             param_reset_o,
    output logic             fault_pulse_o
);
    logic [CTL_W-1:0]  ctrl_reg;
    logic [CTL_W-1:0]  ctrl_next;
    logic [F_W-1:0]    fault_reg;
    logic [F_W-1:0]    fault_prev_reg;
    logic [15:0]       params_reg;
    logic [15:0]       safety_reg;
    logic              thermal_reg;
    logic              host_mode_reg;
    logic              cd_prev_reg;
    logic              skip_reg;
    logic              skip_next;
    logic [31:0]       ovld_cnt_reg;
    logic [31:0]       pulse_cnt_reg;
    logic [31:0]       pulse_cnt_next;
    mode_type          mode_reg;
    mode_type          mode_next;
    logic              pwm_reg;
    logic              charge_en_reg;
    logic              tclr_reg;
    logic              preset_reg;
    logic              stat_oe_reg;
    logic              pulse_on_reg;
    logic [15:0]       rdata_reg;
    logic [15:0]       rdata_next;

    // Register strobes
    wire wr_ctrl   = link.wr && link.addr == REG_CONTROL;
    wire wr_fault  = link.wr && link.addr == REG_FAULT;
    wire wr_params = link.wr && link.addr == REG_PARAMS;
    wire wr_safety = link.wr && link.addr == REG_SAFETY;
    wire param_rst = wr_ctrl && link.wdata[CTL_PARAM_RST];
    wire tmr_rst   = wr_ctrl && link.wdata[CTL_TMR_RST];

    // Thermal latch with resume hysteresis
    wire thermal_next = temp_shutdown_i ? 1'b1 : (temp_resumed_i ? 1'b0 : thermal_reg);

    // Overload counts only while unbroken
    wire ovld_det = ovld_cnt_reg >= 32'(OVLD_CYC);

    wire [F_W-1:0] fault_raw = {bat_low_i, ovld_det, thermal_reg, no_battery_i,
                                !bus_above_uvlo_i, poor_src_i, bat_ov_i, bus_ov_i,
                                sleep_i, timer_fault_i};

    wire otg_boost = host_mode_reg && link.otg && ctrl_reg[CTL_OTG_FUNCTION_ENABLE];
    wire boost_req = ctrl_reg[CTL_OPSEL] || otg_boost;

    // Fault set depends on operating context
    wire [F_W-1:0] ctx_mask  = boost_req ? BOOST_FAULT_MASK : CHARGE_FAULT_MASK;
    wire [F_W-1:0] fault_now = fault_raw & ctx_mask;
    wire           any_fault = |fault_now;
    wire           ovld_block = fault_reg[F_OVERLOAD];
    wire           boost_fault = any_fault || ovld_block;
    wire           fault_event = |(fault_now & ~fault_prev_reg);

    always_comb begin
        if (link.cd || ctrl_reg[CTL_HIZ_REQ]) begin
            mode_next = MODE_HIZ;
        end else if (boost_req) begin
            mode_next = boost_fault ? MODE_CONFIG : MODE_BOOST;
        end else if (any_fault) begin
            mode_next = bus_above_uvlo_i ? MODE_CONFIG : MODE_HIZ;
        end else begin
            mode_next = MODE_CHARGE;
        end
    end

    wire charge_en_next = mode_next == MODE_CHARGE && !ctrl_reg[CTL_INHIBIT]
                          && !thermal_next;

    // Pulse skipping under light load
    always_comb begin
        if (mode_reg != MODE_BOOST) begin
            skip_next = 1'b0;
        end else if (inductor_low_i) begin
            skip_next = 1'b1;
        end else if (node_droop_i) begin
            skip_next = 1'b0;
        end else begin
            skip_next = skip_reg;
        end
    end

    wire pwm_next = charge_en_next || (mode_next == MODE_BOOST && !skip_next
                    && !thermal_next);

    // Fault pulse not retriggered while running
    always_comb begin
        if (pulse_cnt_reg != 32'h0) begin
            pulse_cnt_next = pulse_cnt_reg - 32'h1;
        end else if (fault_event) begin
            pulse_cnt_next = 32'(PULSE_CYC);
        end else begin
            pulse_cnt_next = 32'h0;
        end
    end

    wire stat_oe_next = pulse_cnt_next != 32'h0
                        || (charge_en_next && ctrl_reg[CTL_STAT_EN]);

    // Control register with hardware clear of select bit
    always_comb begin
        ctrl_next = ctrl_reg;
        if (wr_ctrl) begin
            ctrl_next = link.wdata[CTL_W-1:0];
        end
        ctrl_next[CTL_PARAM_RST] = 1'b0;
        ctrl_next[CTL_TMR_RST]   = 1'b0;
        if (ctrl_reg[CTL_OPSEL] && boost_fault) begin
            ctrl_next[CTL_OPSEL] = 1'b0;
        end
    end

    // Read decode
    always_comb begin
        if (link.addr == REG_CONTROL) begin
            rdata_next = {9'h0, ctrl_reg};
        end else if (link.addr == REG_FAULT) begin
            rdata_next = {6'h0, fault_reg};
        end else if (link.addr == REG_STATUS) begin
            rdata_next = {6'h0, stat_oe_reg, host_mode_reg, thermal_reg, skip_reg,
                          charge_en_reg, pwm_reg, mode_reg};
        end else if (link.addr == REG_PARAMS) begin
            rdata_next = params_reg;
        end else if (link.addr == REG_SAFETY) begin
            rdata_next = safety_reg;
        end else begin
            rdata_next = UNMAPPED_READ;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ovld_cnt_reg <= 32'h0;
        end else if (!overload_i || thermal_next) begin
            ovld_cnt_reg <= 32'h0;
        end else if (!ovld_det) begin
            ovld_cnt_reg <= ovld_cnt_reg + 32'h1;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ctrl_reg       <= CTL_RESET;
            fault_reg      <= '0;
            fault_prev_reg <= '0;
            params_reg     <= PARAM_DEFAULT;
            safety_reg     <= SAFETY_DEFAULT;
            thermal_reg    <= 1'b0;
            host_mode_reg  <= 1'b0;
            cd_prev_reg    <= 1'b0;
            skip_reg       <= 1'b0;
            pulse_cnt_reg  <= 32'h0;
            mode_reg       <= MODE_HIZ;
            pwm_reg        <= 1'b0;
            charge_en_reg  <= 1'b0;
            tclr_reg       <= 1'b0;
            preset_reg     <= 1'b0;
            stat_oe_reg    <= 1'b0;
            pulse_on_reg   <= 1'b0;
            rdata_reg      <= 16'h0;
        end else begin
            ctrl_reg       <= ctrl_next;
            // New faults win over a clear in the same cycle
            fault_reg      <= (wr_fault ? '0 : fault_reg) | fault_now;
            fault_prev_reg <= fault_now;
            if (param_rst) begin
                params_reg <= PARAM_DEFAULT;
            end else if (wr_params) begin
                params_reg <= link.wdata;
            end
            if (wr_safety) begin
                safety_reg <= link.wdata;
            end
            thermal_reg    <= thermal_next;
            if (link.wr) begin
                host_mode_reg <= 1'b1;
            end
            cd_prev_reg    <= link.cd;
            skip_reg       <= skip_next;
            pulse_cnt_reg  <= pulse_cnt_next;
            mode_reg       <= mode_next;
            pwm_reg        <= pwm_next;
            charge_en_reg  <= charge_en_next;
            tclr_reg       <= (link.cd && !cd_prev_reg && !host_mode_reg) || tmr_rst;
            preset_reg     <= param_rst;
            stat_oe_reg    <= stat_oe_next;
            pulse_on_reg   <= pulse_cnt_next != 32'h0;
            rdata_reg      <= link.rd ? rdata_next : 16'h0;
        end
    end

    assign mode_o               = mode_reg;
    assign pwm_on_o             = pwm_reg;
    assign charge_en_o          = charge_en_reg;
    assign timers_frozen_o      = thermal_reg;
    assign safety_timer_clear_o = tclr_reg;
    assign host_timer_mode_o    = host_mode_reg;
    assign param_reset_o        = preset_reg;
    assign fault_pulse_o        = pulse_on_reg;
    assign link.stat_o          = 1'b0;
    assign link.stat_oe         = stat_oe_reg;
    assign link.rdata           = rdata_reg;
endmodule

/* dv/charger_mode_fault_control_checker.sv */
// Purpose: Link and status pin checks between host and charger ends
// Assumes: One clock domain, active-low asynchronous reset
// Notes:   Sees only the signals of the link interface
`timescale 1ns/1ps
module charger_mode_fault_control_checker
    import charger_pkg::*;
#(
    parameter int PULSE_CYC = FAULT_PULSE_CYC
) (
    // Clock and reset
    input  wire logic               clk_i,
    input  wire logic               arst_n_i,
    // Host to device
    input  wire logic               cd,
    input  wire logic               otg,
    input  wire logic               wr,
    input  wire logic               rd,
    input  wire logic [LINK_AW-1:0] addr,
    input  wire logic [LINK_DW-1:0] wdata,
    // Device to host
    input  wire logic [LINK_DW-1:0] rdata,
    input  wire logic               stat_o,
    input  wire logic               stat_oe,
    input  wire logic               stat_level
);
    logic [15:0] hi_cnt;
    logic        en_shadow;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);

    // Low stretch length; all ones once status enable was on in it
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            hi_cnt    <= 16'h0000;
            en_shadow <= CTL_RESET[CTL_STAT_EN];
        end else begin
            if (wr && addr == REG_CONTROL) begin
                en_shadow <= wdata[CTL_STAT_EN];
            end
            if (!stat_oe) begin
                hi_cnt <= 16'h0000;
            end else if (en_shadow) begin
                hi_cnt <= 16'hffff;
            end else begin
                hi_cnt <= hi_cnt + {15'h0000, hi_cnt != 16'hffff};
            end
        end
    end

    a_stat_data_low: assert property (stat_o == 1'b0)
        else $error("status pin data not low");
    a_pin_resolve: assert property (stat_level == !stat_oe)
        else $error("status pin level wrong");
    a_pulse_min: assert property ($fell(stat_oe) && !(&hi_cnt) |-> hi_cnt == PULSE_CYC)
        else $error("status low stretch too short");
    a_rdata_idle: assert property (!rd |=> rdata == 16'h0000)
        else $error("read data outside answer cycle");
    a_unmapped_read: assert property (rd && addr > REG_SAFETY |=> rdata == UNMAPPED_READ)
        else $error("unmapped read not all ones");
    a_ctrl_selfclear: assert property (rd && addr == REG_CONTROL |=> !rdata[CTL_PARAM_RST])
        else $error("parameter reset bit reads one");
    a_mode_onehot: assert property (rd && addr == REG_STATUS |=> $onehot(rdata[3:0]))
        else $error("mode not one-hot");
    a_thermal_pwm: assert property (rd && addr == REG_STATUS |=> !(rdata[7] && rdata[4]))
        else $error("converter on in thermal shutdown");
    a_hiz_no_charge: assert property (rd && addr == REG_STATUS |=> !(rdata[5] && rdata[0]))
        else $error("charging in high impedance");
    a_strobe_excl: assert property (!(wr && rd))
        else $error("both link strobes high");

    c_pulse: cover property ($rose(stat_oe));
    c_unmapped: cover property (rd && addr > REG_SAFETY);
    c_fault_clear: cover property (wr && addr == REG_FAULT);
endmodule

/* dv/charger_mode_fault_control_bench.sv */
// Purpose: Self-checking bench joining host and charger ends
// Assumes: Short pulse and overload counts set by parameter
// Notes:   Fault monitors are driven as one vector in fault bit order
`timescale 1ns/1ps
module charger_mode_fault_control_bench
    import charger_pkg::*;
;
    localparam int PCYC = 8;
    logic               clk_i;
    logic               arst_n_i;
    logic               wr_i;
    logic               rd_i;
    logic [USER_AW-1:0] addr_i;
    logic [USER_DW-1:0] wdata_i;
    logic [USER_DW-1:0] rdata_o;
    logic [9:0]         flt;
    logic               tres;
    logic               il;
    logic               nd;
    logic [3:0]         mode_o;
    logic               pwm_o;
    logic               chg_o;
    logic               frz;
    logic               clr_o;
    logic               hmode;
    logic               prst;
    logic               fp;
    logic [31:0]        v;
    logic [31:0]        d;
    logic [31:0]        s;
    int                 n_fail = 0;
    int                 num_checks = 0;
    int                 clr_cnt = 0;
    int                 pr_cnt = 0;
    int                 p_cnt = 0;
    int                 p_w = 0;
    int                 run = 0;
    int                 k;
    int                 bl[4] = '{F_TIMER, F_BUS_OV, F_BAT_OV, F_BAT_LOW};

    charger_link_if lk();
    charger_host u_charger_host (.clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .link(lk));
    charger_dev #(.PULSE_CYC(PCYC), .OVLD_CYC(16)) u_charger_dev (.clk_i(clk_i),
        .arst_n_i(arst_n_i), .link(lk), .temp_shutdown_i(flt[F_THERMAL]),
        .temp_resumed_i(tres), .bus_above_uvlo_i(!flt[F_UVLO]),
        .timer_fault_i(flt[F_TIMER]), .sleep_i(flt[F_SLEEP]), .bus_ov_i(flt[F_BUS_OV]),
        .bat_ov_i(flt[F_BAT_OV]), .poor_src_i(flt[F_POOR_SRC]),
        .no_battery_i(flt[F_NO_BAT]), .overload_i(flt[F_OVERLOAD]),
        .bat_low_i(flt[F_BAT_LOW]), .inductor_low_i(il), .node_droop_i(nd),
        .mode_o(mode_o), .pwm_on_o(pwm_o), .charge_en_o(chg_o), .timers_frozen_o(frz),
        .safety_timer_clear_o(clr_o), .host_timer_mode_o(hmode),
        .param_reset_o(prst), .fault_pulse_o(fp));
    charger_mode_fault_control_checker #(.PULSE_CYC(PCYC))
        u_charger_mode_fault_control_checker (.clk_i(clk_i), .arst_n_i(arst_n_i),
        .cd(lk.cd), .otg(lk.otg), .wr(lk.wr), .rd(lk.rd), .addr(lk.addr),
        .wdata(lk.wdata), .rdata(lk.rdata), .stat_o(lk.stat_o), .stat_oe(lk.stat_oe),
        .stat_level(lk.stat_level));

    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    // Pulse counts and widths seen on the device outputs
    always @(posedge clk_i) begin
        clr_cnt += (clr_o === 1'b1);
        pr_cnt += (prst === 1'b1);
        if (fp === 1'b1)
            run++;
        else if (run != 0) begin
            p_cnt++;
            p_w = run;
            run = 0;
        end
    end

    task automatic w(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic uacc(input logic [2:0] a, input logic [31:0] dat, input bit rd);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= dat;
        if (rd)
            rd_i <= 1'b1;
        else
            wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
        rd_i <= 1'b0;
        @(posedge clk_i);
        v = rdata_o;
    endtask

    task automatic lwr(input logic [2:0] a, input logic [15:0] dat);
        uacc(U_LINK_WR, {13'h0000, a, dat}, 1'b0);
        w(3);
    endtask

    task automatic lrd(input logic [2:0] a);
        uacc(U_LINK_RD, {29'h0, a}, 1'b0);
        w(3);
        uacc(U_RD_DATA, 32'h0, 1'b1);
    endtask

    task automatic lchk(input logic [2:0] a, input logic [15:0] exp);
        lrd(a);
        chk(v[15:0], exp);
    endtask

    task automatic pins(input logic cd, input logic otg);
        uacc(U_PINS, {30'h0, otg, cd}, 1'b0);
        w(3);
    endtask

    task automatic report_and_stop;
        $display("comparisons %0d, mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial begin
        w(20000);
        n_fail++;
        report_and_stop;
    end

    initial begin
        arst_n_i = 1'b0;
        {wr_i, rd_i, tres, il, nd} = 5'h00;
        addr_i = 3'h0;
        wdata_i = 32'h0;
        flt = 10'h000;
        d = $urandom(32'h70af);
        w(5);
        arst_n_i <= 1'b1;
        for (int i = 0; i < 8; i++)
            if (i != 2)
                lchk(3'(i), i == 0 ? 16'h0010 : i > 4 ? 16'hffff : 16'h0000);
        chk({mode_o, chg_o, lk.stat_level, hmode}, {MODE_CHARGE, 3'b100});
        pins(1'b1, 1'b0);
        chk({mode_o, chg_o, 4'(clr_cnt)}, {MODE_HIZ, 5'h01});
        pins(1'b0, 1'b0);
        chk(mode_o, MODE_CHARGE);
        lwr(REG_CONTROL, 16'h0000);
        chk({hmode, lk.stat_level}, 2'b11);
        pins(1'b1, 1'b0);
        pins(1'b0, 1'b0);
        chk(clr_cnt, 1);
        lwr(REG_CONTROL, 16'h0001);
        chk(chg_o, 1'b0);
        lwr(REG_CONTROL, 16'h0002);
        chk(mode_o, MODE_HIZ);
        lwr(REG_CONTROL, 16'h0000);
        chk({mode_o, chg_o}, {MODE_CHARGE, 1'b1});
        d = $urandom & 32'hffff;
        s = $urandom & 32'hffff;
        lwr(REG_PARAMS, d[15:0]);
        lwr(REG_SAFETY, s[15:0]);
        lchk(REG_PARAMS, d[15:0]);
        lwr(REG_CONTROL, 16'h0020);
        chk(pr_cnt, 1);
        lchk(REG_PARAMS, PARAM_DEFAULT);
        lchk(REG_SAFETY, s[15:0]);
        lchk(REG_CONTROL, 16'h0000);
        for (int b = 0; b < 7; b++) begin
            flt[b] <= 1'b1;
            w(4);
            chk(mode_o, b == F_UVLO ? MODE_HIZ : MODE_CONFIG);
            lchk(REG_FAULT, 16'h0001 << b);
            flt[b] <= 1'b0;
            lwr(REG_FAULT, 16'h0000);
            chk(p_cnt * 16 + p_w, (b + 1) * 16 + PCYC);
        end
        flt[F_SLEEP] <= 1'b1;
        w(2);
        flt[F_TIMER] <= 1'b1;
        w(12);
        chk(p_cnt * 16 + p_w, 8 * 16 + PCYC);
        flt <= 10'h000;
        lwr(REG_FAULT, 16'h0000);
        flt[F_THERMAL] <= 1'b1;
        w(4);
        chk({mode_o, pwm_o, chg_o, frz}, {MODE_CONFIG, 3'b001});
        flt[F_THERMAL] <= 1'b0;
        lrd(REG_STATUS);
        chk({v[7], frz}, 2'b11);
        tres <= 1'b1;
        w(4);
        chk({frz, chg_o}, 2'b01);
        tres <= 1'b0;
        lwr(REG_FAULT, 16'h0000);
        foreach (bl[j]) begin
            lwr(REG_CONTROL, 16'h0014);
            chk({mode_o, pwm_o, lk.stat_level}, {MODE_BOOST, 2'b11});
            k = p_cnt;
            flt[bl[j]] <= 1'b1;
            w(4);
            chk(mode_o, bl[j] == F_BAT_LOW ? MODE_CHARGE : MODE_CONFIG);
            lchk(REG_CONTROL, 16'h0010);
            flt[bl[j]] <= 1'b0;
            w(12);
            chk(mode_o, MODE_CHARGE);
            chk((p_cnt - k) * 16 + p_w, 16 + PCYC);
            lwr(REG_FAULT, 16'h0000);
        end
        lwr(REG_CONTROL, 16'h0014);
        flt[F_OVERLOAD] <= 1'b1;
        w(10);
        flt[F_OVERLOAD] <= 1'b0;
        w(2);
        chk(mode_o, MODE_BOOST);
        flt[F_OVERLOAD] <= 1'b1;
        w(20);
        flt[F_OVERLOAD] <= 1'b0;
        lwr(REG_CONTROL, 16'h0014);
        chk(mode_o, MODE_CHARGE);
        lwr(REG_FAULT, 16'h0000);
        lwr(REG_CONTROL, 16'h0014);
        chk(mode_o, MODE_BOOST);
        il <= 1'b1;
        w(1);
        il <= 1'b0;
        w(2);
        chk(pwm_o, 1'b0);
        nd <= 1'b1;
        w(1);
        nd <= 1'b0;
        w(2);
        chk(pwm_o, 1'b1);
        lwr(REG_CONTROL, 16'h0018);
        chk(mode_o, MODE_CHARGE);
        pins(1'b0, 1'b1);
        chk(mode_o, MODE_BOOST);
        report_and_stop;
    end
endmodule
